// ===== rss_defs.svh
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

`define RSS_CLK_PERIOD_NS 8
`define RSS_POWER_ON_WAIT_NS 250000
`define RSS_RESET_LOW_WIDTH_NS 250000
`define RSS_MOD_SETTLE_TICKS 256
`define RSS_FILTER_START_TICKS 44
`define RSS_OVERSAMPLING_RATIO 1024
`define RSS_GC_DELAY_TICKS 2
`define RSS_CHOP_CONVERSIONS 3
`define RSS_SAMPLE_READY_LOW_TICKS 4
`define RSS_FAST_RESULTS 2
`define RSS_WORD_BITS 24
`define RSS_FRAME_WORDS 5
`define RSS_CMD_BITS 16
`define RSS_CMD_RESET 16'h0011

`endif

// ===== rss_pkg.sv
package rss_pkg;
  typedef enum logic [2:0] {
    RSS_POR_WAIT,
    RSS_PIN_HOLD,
    RSS_CMD_RESET,
    RSS_CLK_WAIT,
    RSS_STARTUP,
    RSS_CONVERT
  } rss_state_t;
endpackage

// ===== rss_frame_if.sv
`timescale 1ns/100ps
interface rss_frame_if;
  logic enable;
  logic frame_active;
  logic cmd_reset;
  modport rx (
    input enable,
    output frame_active,
    output cmd_reset
  );
  modport ctl (
    output enable,
    input frame_active,
    input cmd_reset
  );
endinterface

// ===== rss_frame_rx.sv
`timescale 1ns/100ps
`include "rss_defs.svh"
module rss_frame_rx
  import rss_pkg::*;
#(
  parameter int WORD_BITS = `RSS_WORD_BITS,
  parameter int FRAME_WORDS = `RSS_FRAME_WORDS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  rss_frame_if.rx frm
);
  localparam int FRAME_BITS = WORD_BITS * FRAME_WORDS;
  localparam int CNT_W = $clog2(FRAME_BITS + 2);

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [1:0] mosi_s;
    logic [CNT_W-1:0] bit_cnt;
    logic [`RSS_CMD_BITS-1:0] cmd;
    logic cmd_reset;
  } rss_rx_t;

  rss_rx_t s;
  rss_rx_t next_s;

  always_comb begin
    logic sclk_rise;
    logic cs_rise;
    logic cs_low;
    sclk_rise = 1'b0;
    cs_rise = 1'b0;
    cs_low = 1'b0;
    next_s = s;
    next_s.sclk_s = {s.sclk_s[1:0], sclk};
    next_s.cs_s = {s.cs_s[1:0], cs_n};
    next_s.mosi_s = {s.mosi_s[0], mosi};
    next_s.cmd_reset = 1'b0;
    sclk_rise = s.sclk_s[1] & ~s.sclk_s[2];
    cs_rise = s.cs_s[1] & ~s.cs_s[2];
    cs_low = ~s.cs_s[1];
    if (cs_low && sclk_rise) begin
      // Command is the top of the first word; later bits only count
      if (s.bit_cnt < CNT_W'(`RSS_CMD_BITS)) begin
        next_s.cmd = {s.cmd[`RSS_CMD_BITS-2:0], s.mosi_s[1]};
      end
      if (s.bit_cnt <= CNT_W'(FRAME_BITS)) begin
        next_s.bit_cnt = s.bit_cnt + CNT_W'(1);
      end
    end
    if (cs_rise) begin
      // Frame end: act only on a full five-word frame taken while ready
      if (frm.enable && s.bit_cnt == CNT_W'(FRAME_BITS)
          && s.cmd == `RSS_CMD_RESET) begin
        next_s.cmd_reset = 1'b1;
      end
      next_s.bit_cnt = '0;
      next_s.cmd = '0;
    end
    if (!rst_n) begin
      next_s.bit_cnt = '0;
      next_s.cmd = '0;
      next_s.cmd_reset = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign frm.cmd_reset = s.cmd_reset;
  assign frm.frame_active = ~s.cs_s[2];
endmodule

// ===== rss_reset_startup_sequencer.sv
// Function
// - Reset comes from power-on, a long low on the reset pin, or a command.
// - Any reset restores register defaults; conversions start once modulator clock runs.
// - Sample-ready rising edge marks serial readiness; earlier frames are discarded.
// - After power-on wait sample-ready rises; defaults load during the wait.
// - Reset pin must stay low longer than the minimum width to reset.
// - Pin reset holds while the pin is low, releases when it goes high.
// - Reset command code is 0011h in the first word of the frame.
// - Reset command acts only after the whole frame has been clocked.
// - A frame ended early discards the reset command.
// - A complete frame is exactly five words; host clocks all five.
// - Reset follows the latched command at once; host then waits settle time.
// - Sampling starts after modulator clock toggles plus 256 plus 44 periods.
// - Fast path settles in one data period, sinc3 in three; both fed together.
// - First two results come from the fast path, each with a falling edge.
// - Third and later results come from the sinc3 path.
// - Pin or command reset skips power-on wait but keeps startup delay.
// - Two conversion modes: continuous and global-chop.
// - Continuous mode gives a result each oversampling ratio modulator periods.
`timescale 1ns/100ps
`include "rss_defs.svh"
module rss_reset_startup_sequencer
  import rss_pkg::*;
#(
  parameter int POWER_ON_WAIT_CYC =
    (`RSS_POWER_ON_WAIT_NS + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS,
  parameter int RESET_LOW_WIDTH_CYC =
    (`RSS_RESET_LOW_WIDTH_NS + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS,
  parameter int OVERSAMPLING_RATIO = `RSS_OVERSAMPLING_RATIO,
  parameter int GC_DELAY_TICKS = `RSS_GC_DELAY_TICKS,
  parameter int WORD_BITS = `RSS_WORD_BITS,
  parameter int FRAME_WORDS = `RSS_FRAME_WORDS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic modulator_clock_in,
  input wire logic global_chop_en,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic sample_ready_n,
  output logic config_reset,
  output logic spi_ready,
  output logic modulator_run,
  output logic fast_filter_en,
  output logic result_valid,
  output logic result_from_sinc3
);
  localparam int CNT_W = 32;
  localparam int STARTUP_TICKS = `RSS_MOD_SETTLE_TICKS + `RSS_FILTER_START_TICKS;
  localparam int CONT_PERIOD = OVERSAMPLING_RATIO;
  localparam int CHOP_PERIOD = GC_DELAY_TICKS + `RSS_CHOP_CONVERSIONS * OVERSAMPLING_RATIO;

  typedef struct packed {
    rss_state_t state;
    logic [1:0] pin_s;
    logic [2:0] mclk_s;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] cnt;
    logic [7:0] ready_low_cnt;
    logic [1:0] conv_cnt;
    logic sample_ready_n;
    logic result_valid;
    logic result_from_sinc3;
  } rss_seq_t;

  rss_seq_t s;
  rss_seq_t next_s;

  rss_frame_if frm ();

  rss_frame_rx #(
    .WORD_BITS(WORD_BITS),
    .FRAME_WORDS(FRAME_WORDS)
  ) u_frame_rx (
    .clk(clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .frm(frm.rx)
  );

  function automatic logic in_reset(input rss_state_t st);
    in_reset = (st == RSS_POR_WAIT) || (st == RSS_PIN_HOLD) || (st == RSS_CMD_RESET);
  endfunction

  always_comb begin
    logic mod_tick;
    logic pin_low;
    logic pin_trig;
    logic [CNT_W-1:0] period;
    mod_tick = 1'b0;
    pin_low = 1'b0;
    pin_trig = 1'b0;
    period = '0;
    next_s = s;
    next_s.pin_s = {s.pin_s[0], reset_pin_n};
    next_s.mclk_s = {s.mclk_s[1:0], modulator_clock_in};
    next_s.result_valid = 1'b0;
    // One modulator period per rising edge of the sampled clock
    mod_tick = s.mclk_s[1] & ~s.mclk_s[2];
    pin_low = ~s.pin_s[1];
    period = global_chop_en ? CNT_W'(CHOP_PERIOD) : CNT_W'(CONT_PERIOD);

    // Low-time counter saturates so a held pin keeps triggering
    if (pin_low) begin
      if (s.low_cnt <= CNT_W'(RESET_LOW_WIDTH_CYC)) begin
        next_s.low_cnt = s.low_cnt + CNT_W'(1);
      end
    end else begin
      next_s.low_cnt = '0;
    end
    pin_trig = pin_low && (s.low_cnt >= CNT_W'(RESET_LOW_WIDTH_CYC));

    // Sample-ready low pulse after each result
    if (s.ready_low_cnt != 8'h00 && mod_tick) begin
      next_s.ready_low_cnt = s.ready_low_cnt - 8'h01;
      if (s.ready_low_cnt == 8'h01) begin
        next_s.sample_ready_n = 1'b1;
      end
    end

    case (s.state)
      RSS_POR_WAIT: begin
        next_s.sample_ready_n = 1'b0;
        next_s.cnt = s.cnt + CNT_W'(1);
        if (s.cnt >= CNT_W'(POWER_ON_WAIT_CYC - 1)) begin
          next_s.state = RSS_CLK_WAIT;
          next_s.sample_ready_n = 1'b1;
          next_s.cnt = '0;
        end
      end
      RSS_PIN_HOLD: begin
        next_s.sample_ready_n = 1'b0;
        if (!pin_low) begin
          // No power-on wait here, straight to startup delay
          next_s.state = RSS_CLK_WAIT;
          next_s.sample_ready_n = 1'b1;
        end
      end
      RSS_CMD_RESET: begin
        next_s.state = RSS_CLK_WAIT;
        next_s.sample_ready_n = 1'b1;
      end
      RSS_CLK_WAIT: begin
        if (mod_tick) begin
          next_s.state = RSS_STARTUP;
          next_s.cnt = CNT_W'(1);
        end
      end
      RSS_STARTUP: begin
        if (mod_tick) begin
          next_s.cnt = s.cnt + CNT_W'(1);
          if (s.cnt >= CNT_W'(STARTUP_TICKS - 1)) begin
            next_s.state = RSS_CONVERT;
            next_s.cnt = '0;
            next_s.conv_cnt = 2'b00;
          end
        end
      end
      RSS_CONVERT: begin
        if (mod_tick) begin
          next_s.cnt = s.cnt + CNT_W'(1);
          if (s.cnt >= period - CNT_W'(1)) begin
            next_s.cnt = '0;
            next_s.result_valid = 1'b1;
            next_s.sample_ready_n = 1'b0;
            next_s.ready_low_cnt = 8'(`RSS_SAMPLE_READY_LOW_TICKS);
            next_s.result_from_sinc3 = (s.conv_cnt >= 2'(`RSS_FAST_RESULTS));
            if (s.conv_cnt != 2'b11) begin
              next_s.conv_cnt = s.conv_cnt + 2'b01;
            end
          end
        end
      end
      default: begin
        next_s.state = RSS_POR_WAIT;
      end
    endcase

    // Pin reset beats command reset; both drop any conversion in flight
    if (pin_trig) begin
      next_s.state = RSS_PIN_HOLD;
      next_s.sample_ready_n = 1'b0;
      next_s.ready_low_cnt = 8'h00;
      next_s.cnt = '0;
      next_s.conv_cnt = 2'b00;
      next_s.result_from_sinc3 = 1'b0;
      next_s.result_valid = 1'b0;
    end else if (frm.cmd_reset) begin
      next_s.state = RSS_CMD_RESET;
      next_s.sample_ready_n = 1'b0;
      next_s.ready_low_cnt = 8'h00;
      next_s.cnt = '0;
      next_s.conv_cnt = 2'b00;
      next_s.result_from_sinc3 = 1'b0;
      next_s.result_valid = 1'b0;
    end

    if (!rst_n) begin
      next_s.state = RSS_POR_WAIT;
      next_s.low_cnt = '0;
      next_s.cnt = '0;
      next_s.ready_low_cnt = 8'h00;
      next_s.conv_cnt = 2'b00;
      next_s.sample_ready_n = 1'b0;
      next_s.result_valid = 1'b0;
      next_s.result_from_sinc3 = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  // Frames are only accepted once readiness has been signalled
  assign frm.enable = ~in_reset(s.state);
  assign spi_ready = ~in_reset(s.state);
  assign config_reset = in_reset(s.state);
  assign sample_ready_n = s.sample_ready_n;
  assign modulator_run = (s.state == RSS_CONVERT);
  assign fast_filter_en = ~in_reset(s.state) && (s.conv_cnt < 2'(`RSS_FAST_RESULTS));
  assign result_valid = s.result_valid;
  assign result_from_sinc3 = s.result_from_sinc3;
endmodule

// ===== rss_reset_startup_sequencer_asserts.sv
`timescale 1ns/100ps
module rss_seq_asserts #(
  parameter int RESET_LOW_WIDTH_CYC = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic sample_ready_n,
  input wire logic config_reset,
  input wire logic spi_ready,
  input wire logic modulator_run,
  input wire logic result_valid,
  input wire logic result_from_sinc3
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] lo;
  logic [2:0] hi;
  logic [3:0] nres;
  // Low run of the pin, kept until the pin has been high for four cycles
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lo <= 16'h0;
      hi <= 3'h0;
      nres <= 4'h0;
    end else begin
      hi <= reset_pin_n ? hi + 3'(hi != 3'h7) : 3'h0;
      lo <= (hi == 3'h4) ? 16'h0 : lo + 16'(!reset_pin_n && lo != 16'hFFFF);
      nres <= config_reset ? 4'h0 : nres + 4'(result_valid && nres != 4'hF);
    end
  end
  sequence s_result;
    result_valid && $fell(sample_ready_n);
  endsequence
  sequence s_low4;
    !sample_ready_n [*4];
  endsequence
  a_result_fall: assert property (result_valid |-> s_result ##1 s_low4)
    else $error("result without sample ready fall");
  a_ready_low_rst: assert property (config_reset |-> !sample_ready_n)
    else $error("sample ready high during reset");
  a_ready_inverse: assert property (spi_ready == !config_reset)
    else $error("serial ready not inverse of reset");
  a_ready_edge: assert property ($rose(spi_ready) |-> $rose(sample_ready_n))
    else $error("serial ready without sample ready rise");
  a_filter_order: assert property (result_valid |-> result_from_sinc3 == (nres >= 4'h2))
    else $error("wrong filter for result");
  a_run_clear: assert property (modulator_run |-> !config_reset)
    else $error("modulator runs in reset");
  a_valid_run: assert property (result_valid |-> modulator_run)
    else $error("result while not converting");
  a_pin_short: assert property ($rose(config_reset) |-> lo >= RESET_LOW_WIDTH_CYC || hi == 3'h7)
    else $error("reset from short pin pulse");
  a_pin_hold: assert property (!reset_pin_n && lo >= RESET_LOW_WIDTH_CYC + 4 |-> config_reset)
    else $error("no reset while pin held low");
endmodule
bind rss_reset_startup_sequencer rss_seq_asserts #(.RESET_LOW_WIDTH_CYC(RESET_LOW_WIDTH_CYC)) rss_seq_asserts_i (
  .clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .sample_ready_n(sample_ready_n),
  .config_reset(config_reset), .spi_ready(spi_ready), .modulator_run(modulator_run),
  .result_valid(result_valid), .result_from_sinc3(result_from_sinc3));

// ===== rss_host_model.sv
`timescale 1ns/100ps
module rss_host_model (
  input wire logic clk,
  output logic reset_pin_n,
  output logic modulator_clock_in,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  logic mclk_on;
  initial begin
    mclk_on = 1'b0;
    modulator_clock_in = 1'b0;
    sclk = 1'b0;
    reset_pin_n = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
    #5.3;
    forever #32 modulator_clock_in <= mclk_on & ~modulator_clock_in;
  end
  // Released data line shows a changing pattern
  always @(posedge clk) if (cs_n) mosi <= ~mosi;
  task automatic pin_pulse(input int n);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge clk);
    reset_pin_n <= 1'b1;
  endtask
  task automatic send_frame(input logic [15:0] code, input int nbits);
    logic [119:0] w;
    w = {code, 104'h0};
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      repeat (8) @(posedge clk);
      mosi <= (i < 120) ? w[119 - i] : 1'b0;
      repeat (8) @(posedge clk);
      sclk <= 1'b1;
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    cs_n <= 1'b1;
  endtask
endmodule

// ===== rss_reset_startup_sequencer_tb.sv
`timescale 1ns/100ps
module rss_reset_startup_sequencer_tb;
  localparam int W = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic gc = 1'b0;
  logic sample_ready_n, config_reset, spi_ready, modulator_run, fast_filter_en, result_valid, result_from_sinc3;
  logic reset_pin_n, modulator_clock_in, sclk, cs_n, mosi;
  logic [31:0] seed = 32'h0000A2FC;
  int fails = 0;
  int comparisons = 0;
  int rises = 0;
  int nres = 0;
  int t;
  always #4 clk = ~clk;
  always @(posedge modulator_clock_in) rises++;
  rss_reset_startup_sequencer #(.POWER_ON_WAIT_CYC(20), .RESET_LOW_WIDTH_CYC(W), .OVERSAMPLING_RATIO(8))
    rss_reset_startup_sequencer_i (.clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
    .modulator_clock_in(modulator_clock_in), .global_chop_en(gc), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .sample_ready_n(sample_ready_n), .config_reset(config_reset), .spi_ready(spi_ready),
    .modulator_run(modulator_run), .fast_filter_en(fast_filter_en), .result_valid(result_valid),
    .result_from_sinc3(result_from_sinc3));
  rss_host_model rss_host_model_i (.clk(clk), .reset_pin_n(reset_pin_n), .modulator_clock_in(modulator_clock_in),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic exp_sinc3(input int n);
    return n >= 2;
  endfunction
  task automatic stop_test;
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  // Waits for serial readiness (sel 0) or a result (sel 1)
  task automatic wait_until(input int sel, input int lim);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (!(sel == 0 ? spi_ready === 1'b1 : result_valid === 1'b1) && k < lim);
    if (k >= lim) begin
      fails++;
      stop_test();
    end
  endtask
  // Polls config_reset for up to n cycles; stops at the first sighting
  task automatic watch_reset(input int n, output int seen);
    seen = 0;
    for (int k = 0; k < n && seen == 0; k++) begin
      @(posedge clk);
      #1;
      seen = int'(config_reset === 1'b1);
    end
  endtask
  task automatic startup_check(input string name);
    wait_until(0, 40);
    t = rises;
    wait_until(1, 3000);
    check(name, 32'h1, 32'(rises - t >= 307 && rises - t <= 309));
  endtask
  // Hosts wanting full precision would skip the first two results
  always @(negedge clk) begin
    if (rst_n !== 1'b1 || config_reset === 1'b1) nres = 0;
    else if (result_valid === 1'b1) begin
      check("result_from_sinc3", 32'(exp_sinc3(nres)), 32'(result_from_sinc3));
      nres++;
    end
    else check("fast_filter_en", 32'(nres < 2), 32'(fast_filter_en));
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check("ready_in_por", 32'h0, 32'(sample_ready_n));
    wait_until(0, 40);
    check("ready_after_por", 32'h1, 32'(sample_ready_n));
    rss_host_model_i.mclk_on = 1'b1;
    rises = 0;
    wait_until(1, 3000);
    check("first_result", 32'd308, 32'(rises));
    for (int i = 0; i < 3; i++) begin
      t = rises;
      wait_until(1, 200);
      check("result_period", 32'd8, 32'(rises - t));
    end
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      rss_host_model_i.pin_pulse(1 + seed % (W - 2));
      watch_reset(6, t);
      check("short_pulse", 32'h0, 32'(t));
    end
    fork rss_host_model_i.pin_pulse(W + 30); join_none
    repeat (W + 20) @(posedge clk);
    #1;
    check("pin_hold", 32'h1, 32'(config_reset));
    startup_check("pin_startup");
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      rss_host_model_i.send_frame(i == 1 ? seed[15:0] | 16'h0100 : 16'h0011,
        i == 0 ? 24 * (1 + seed % 4) : 120 + i / 2);
      watch_reset(12, t);
      check("bad_frame", 32'h0, 32'(t));
    end
    fork rss_host_model_i.send_frame(16'h0011, 120); join_none
    watch_reset(120 * 24 + 4, t);
    check("cmd_early", 32'h0, 32'(t));
    watch_reset(20, t);
    check("cmd_reset", 32'h1, 32'(t));
    startup_check("cmd_startup");
    @(posedge clk);
    gc <= 1'b1;
    wait_until(1, 400);
    wait_until(1, 400);
    t = rises;
    wait_until(1, 400);
    check("chop_period", 32'd26, 32'(rises - t));
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check("ready_in_reset", 32'h0, 32'(sample_ready_n));
    check("config_in_reset", 32'h1, 32'(config_reset));
    @(posedge clk);
    rst_n <= 1'b1;
    wait_until(0, 40);
    check("ready_after_reset", 32'h1, 32'(sample_ready_n));
    stop_test();
  end
endmodule
